// file: src/core_memory_map.sv
`timescale 1ns/1ns
`default_nettype none
`include "core_map_map.svh"

module core_memory_map
    import core_map_pkg::*;
#(
    parameter int RAM_DEPTH  = 256,
    parameter int INTERNAL_EXTENDED_RAM_DEPTH = 2048,
    parameter int INTERNAL_EXTENDED_RAM_AW    = 11
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        code_source_select_i,
    input  wire logic        fetch_req_i,
    input  wire logic [15:0] fetch_addr_i,
    input  wire req_t        req_i,
    input  wire logic [7:0]  acc_i,
    input  wire logic [7:0]  ext_data_i,
    output logic             code_internal_o,
    output logic             fetch_valid_o,
    output logic             fetch_nop_o,
    output logic             fetch_external_o,
    output logic             busy_o,
    output logic             rsp_valid_o,
    output logic [7:0]       rsp_data_o,
    output logic             rsp_unmapped_o,
    output logic [1:0]       bank_select_o,
    output logic [23:0]      ext_addr_o,
    output logic [7:0]       ext_data_o,
    output logic             ext_data_oe_n_o,
    output logic             ext_rd_n_o,
    output logic             ext_wr_n_o,
    output logic             ext_cycle_o
);

    regs_t r;
    regs_t next_r;

    logic [7:0]         ram [RAM_DEPTH];
    logic               ram_we;
    logic [7:0]         ram_addr;
    logic [7:0]         ram_wdata;
    logic               internal_extended_ram_we;
    logic [INTERNAL_EXTENDED_RAM_AW-1:0] internal_extended_ram_addr;
    logic [7:0]         internal_extended_ram_wdata;
    logic [7:0]         internal_extended_ram_rdata;
    logic [7:0]         psw_now;
    logic [23:0]        data_pointer;

    assign psw_now = {r.program_status_word[7:1], ^acc_i};
    assign data_pointer    = {r.pointer_page_byte, r.pointer_high_byte, r.pointer_low_byte};

    // Special-space read decode
    function automatic logic [8:0] sfr_read(input logic [7:0] a);
        logic [8:0] v;
        v = {1'b0, 8'h00};
        case (a)
            `MAP_SP_LOW_ADDR:  v = {1'b1, r.sp[7:0]};
            `MAP_SP_HIGH_ADDR: v = {1'b1, 5'b00000, r.sp[10:8]};
            `MAP_DP_LOW_ADDR:  v = {1'b1, r.pointer_low_byte};
            `MAP_DP_HIGH_ADDR: v = {1'b1, r.pointer_high_byte};
            `MAP_DP_PAGE_ADDR: v = {1'b1, r.pointer_page_byte};
            `MAP_PSW_ADDR:     v = {1'b1, psw_now};
            `MAP_CONFIG_ADDR: begin
                v = {1'b1, r.exsp, 6'b000000, r.internal_extended_ram_en};
            end
            default:           v = {1'b0, 8'h00};
        endcase
        return v;
    endfunction

    // Bit address to byte address
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        if (a < `MAP_SFR_SPACE_BASE) begin
            b = `MAP_BIT_AREA_BASE + {4'h0, a[6:3]};
        end else begin
            b = {a[7:3], 3'b000};
        end
        return b;
    endfunction

    always_comb begin
        logic [8:0]  sfr_v;
        logic [7:0]  byte_a;
        logic [7:0]  byte_v;
        logic        sfr_we;
        logic [7:0]  sfr_wa;
        logic [7:0]  sfr_wd;
        logic [10:0] nsp;
        logic        ext_go;
        next_r      = r;
        sfr_v       = 9'h000;
        byte_a      = 8'h00;
        byte_v      = 8'h00;
        sfr_we      = 1'b0;
        sfr_wa      = 8'h00;
        sfr_wd      = 8'h00;
        nsp         = r.sp;
        ext_go      = 1'b0;
        ram_we      = 1'b0;
        ram_addr    = req_i.addr;
        ram_wdata   = req_i.wdata;
        internal_extended_ram_we     = 1'b0;
        internal_extended_ram_addr   = data_pointer[INTERNAL_EXTENDED_RAM_AW-1:0];
        internal_extended_ram_wdata  = req_i.wdata;

        next_r.rsp_valid    = 1'b0;
        next_r.rsp_unmapped = 1'b0;
        next_r.fetch_valid  = fetch_req_i && r.state == ST_IDLE;
        next_r.fetch_nop    = r.code_internal && fetch_addr_i >= `MAP_NOP_REGION_BASE;
        next_r.fetch_external = !r.code_internal;

        case (r.state)
            ST_STRAP: begin
                next_r.code_internal = code_source_select_i;
                next_r.state         = ST_IDLE;
                next_r.busy          = 1'b0;
                next_r.fetch_valid   = 1'b0;
            end
            ST_IDLE: begin
                next_r.rsp_valid = req_i.op != OP_IDLE;
                case (req_i.op)
                    OP_RD_DIRECT: begin
                        if (req_i.addr < `MAP_SFR_SPACE_BASE) begin
                            next_r.rsp_data = ram[req_i.addr];
                        end else begin
                            sfr_v = sfr_read(req_i.addr);
                            next_r.rsp_data     = sfr_v[7:0];
                            next_r.rsp_unmapped = !sfr_v[8];
                        end
                    end
                    OP_WR_DIRECT: begin
                        if (req_i.addr < `MAP_SFR_SPACE_BASE) begin
                            ram_we = 1'b1;
                        end else begin
                            sfr_we = 1'b1;
                            sfr_wa = req_i.addr;
                            sfr_wd = req_i.wdata;
                            sfr_v  = sfr_read(req_i.addr);
                            next_r.rsp_unmapped = !sfr_v[8];
                        end
                    end
                    OP_RD_INDIRECT: begin
                        next_r.rsp_data = ram[req_i.addr];
                    end
                    OP_WR_INDIRECT: begin
                        ram_we = 1'b1;
                    end
                    OP_RD_WORKREG, OP_WR_WORKREG: begin
                        ram_addr = {3'b000, r.program_status_word[`MAP_PSW_BANK_HI:`MAP_PSW_BANK_LO],
                                    req_i.addr[2:0]};
                        ram_we          = req_i.op == OP_WR_WORKREG;
                        next_r.rsp_data = ram[ram_addr];
                    end
                    OP_RD_BIT, OP_WR_BIT: begin
                        byte_a = bit_byte(req_i.addr);
                        if (req_i.addr < `MAP_SFR_SPACE_BASE) begin
                            byte_v = ram[byte_a];
                        end else begin
                            sfr_v  = sfr_read(byte_a);
                            byte_v = sfr_v[7:0];
                            next_r.rsp_unmapped = !sfr_v[8];
                        end
                        next_r.rsp_data = {7'h00, byte_v[req_i.addr[2:0]]};
                        if (req_i.op == OP_WR_BIT) begin
                            byte_v[req_i.addr[2:0]] = req_i.wdata[0];
                            if (req_i.addr < `MAP_SFR_SPACE_BASE) begin
                                ram_we    = 1'b1;
                                ram_addr  = byte_a;
                                ram_wdata = byte_v;
                            end else begin
                                sfr_we = 1'b1;
                                sfr_wa = byte_a;
                                sfr_wd = byte_v;
                            end
                        end
                    end
                    OP_PUSH: begin
                        if (r.exsp) begin
                            nsp = r.sp + 11'h001;
                        end else begin
                            nsp = {3'b000, r.sp[7:0] + 8'h01};
                        end
                        next_r.sp = nsp;
                        if (r.exsp && nsp >= `MAP_STACK_INTERNAL_EXTENDED_RAM_BASE) begin
                            internal_extended_ram_we   = 1'b1;
                            internal_extended_ram_addr = nsp[INTERNAL_EXTENDED_RAM_AW-1:0];
                        end else begin
                            ram_we   = 1'b1;
                            ram_addr = nsp[7:0];
                        end
                    end
                    OP_POP: begin
                        if (r.exsp && r.sp >= `MAP_STACK_INTERNAL_EXTENDED_RAM_BASE) begin
                            internal_extended_ram_addr       = r.sp[INTERNAL_EXTENDED_RAM_AW-1:0];
                            next_r.rsp_data = internal_extended_ram_rdata;
                        end else begin
                            next_r.rsp_data = ram[r.sp[7:0]];
                        end
                        if (r.exsp) begin
                            next_r.sp = r.sp - 11'h001;
                        end else begin
                            next_r.sp = {3'b000, r.sp[7:0] - 8'h01};
                        end
                    end
                    OP_XRD, OP_XWR: begin
                        if (r.internal_extended_ram_en && data_pointer <= `MAP_INTERNAL_EXTENDED_RAM_LIMIT) begin
                            internal_extended_ram_we         = req_i.op == OP_XWR;
                            next_r.rsp_data = internal_extended_ram_rdata;
                        end else begin
                            ext_go = 1'b1;
                        end
                    end
                    OP_DP_INC: begin
                        {next_r.pointer_page_byte, next_r.pointer_high_byte, next_r.pointer_low_byte} = data_pointer + 24'h000001;
                    end
                    default: begin
                        next_r.rsp_valid = 1'b0;
                    end
                endcase
                if (ext_go) begin
                    next_r.rsp_valid = 1'b0;
                    next_r.state     = ST_EXT;
                    next_r.busy      = 1'b1;
                    next_r.ext_cycle = 1'b1;
                    next_r.ext_addr  = data_pointer;
                    next_r.ext_data  = req_i.wdata;
                    next_r.ext_rd_n  = req_i.op != OP_XRD;
                    next_r.ext_wr_n  = req_i.op != OP_XWR;
                    next_r.ext_oe_n  = req_i.op != OP_XWR;
                end
            end
            ST_EXT: begin
                next_r.rsp_valid = 1'b1;
                if (!r.ext_rd_n) begin
                    next_r.rsp_data = ext_data_i;
                end
                next_r.ext_rd_n  = 1'b1;
                next_r.ext_wr_n  = 1'b1;
                next_r.ext_oe_n  = 1'b1;
                next_r.ext_cycle = 1'b0;
                next_r.state     = ST_IDLE;
                next_r.busy      = 1'b0;
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.busy  = 1'b0;
            end
        endcase

        // Special-space writes
        if (sfr_we) begin
            case (sfr_wa)
                `MAP_SP_LOW_ADDR:  next_r.sp[7:0]  = sfr_wd;
                `MAP_SP_HIGH_ADDR: next_r.sp[10:8] = sfr_wd[2:0];
                `MAP_DP_LOW_ADDR:  next_r.pointer_low_byte      = sfr_wd;
                `MAP_DP_HIGH_ADDR: next_r.pointer_high_byte      = sfr_wd;
                `MAP_DP_PAGE_ADDR: next_r.pointer_page_byte      = sfr_wd;
                `MAP_PSW_ADDR: begin
                    next_r.program_status_word = {sfr_wd[7:1], 1'b0};
                end
                `MAP_CONFIG_ADDR: begin
                    next_r.exsp    = sfr_wd[`MAP_CFG_EXSP_BIT];
                    next_r.internal_extended_ram_en = sfr_wd[`MAP_CFG_INTERNAL_EXTENDED_RAM_BIT];
                end
                default: begin
                    next_r.rsp_unmapped = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r                <= '0;
            r.state          <= ST_STRAP;
            r.busy           <= 1'b1;
            r.sp             <= `MAP_SP_RESET;
            r.program_status_word            <= `MAP_PSW_RESET;
            r.pointer_low_byte            <= `MAP_DP_RESET;
            r.pointer_high_byte            <= `MAP_DP_RESET;
            r.pointer_page_byte            <= `MAP_DP_RESET;
            r.exsp           <= 1'b0;
            r.internal_extended_ram_en        <= 1'b0;
            r.ext_oe_n       <= 1'b1;
            r.ext_rd_n       <= 1'b1;
            r.ext_wr_n       <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (ram_we) begin
            ram[ram_addr] <= ram_wdata;
        end
    end

    internal_extended_ram_store #(
        .DEPTH (INTERNAL_EXTENDED_RAM_DEPTH),
        .AW    (INTERNAL_EXTENDED_RAM_AW)
    ) u_internal_extended_ram (
        .sys_clk_i (sys_clk_i),
        .we_i      (internal_extended_ram_we),
        .addr_i    (internal_extended_ram_addr),
        .wdata_i   (internal_extended_ram_wdata),
        .rdata_o   (internal_extended_ram_rdata)
    );

    assign code_internal_o  = r.code_internal;
    assign fetch_valid_o    = r.fetch_valid;
    assign fetch_nop_o      = r.fetch_nop;
    assign fetch_external_o = r.fetch_external;
    assign busy_o           = r.busy;
    assign rsp_valid_o      = r.rsp_valid;
    assign rsp_data_o       = r.rsp_data;
    assign rsp_unmapped_o   = r.rsp_unmapped;
    assign bank_select_o    = r.program_status_word[`MAP_PSW_BANK_HI:`MAP_PSW_BANK_LO];
    assign ext_addr_o       = r.ext_addr;
    assign ext_data_o       = r.ext_data;
    assign ext_data_oe_n_o  = r.ext_oe_n;
    assign ext_rd_n_o       = r.ext_rd_n;
    assign ext_wr_n_o       = r.ext_wr_n;
    assign ext_cycle_o      = r.ext_cycle;

endmodule

`default_nettype wire

// file: src/core_map_map.svh
`ifndef CORE_MAP_MAP_SVH
`define CORE_MAP_MAP_SVH

// Special-register addresses
`define MAP_SP_LOW_ADDR      8'h81
`define MAP_DP_LOW_ADDR      8'h82
`define MAP_DP_HIGH_ADDR     8'h83
`define MAP_DP_PAGE_ADDR     8'h84
`define MAP_CONFIG_ADDR      8'haf
`define MAP_SP_HIGH_ADDR     8'hb7
`define MAP_PSW_ADDR         8'hd0

// Reset values
`define MAP_SP_RESET         11'h007
`define MAP_PSW_RESET        8'h00
`define MAP_CONFIG_RESET     8'h00
`define MAP_DP_RESET         8'h00

// Field positions
`define MAP_CFG_EXSP_BIT     7
`define MAP_CFG_INTERNAL_EXTENDED_RAM_BIT     0
`define MAP_PSW_BANK_HI      4
`define MAP_PSW_BANK_LO      3
`define MAP_PSW_PARITY_BIT   0

// Space boundaries
`define MAP_SFR_SPACE_BASE   8'h80
`define MAP_BIT_AREA_BASE    8'h20
`define MAP_NOP_REGION_BASE  16'hf800
`define MAP_NOP_OPCODE       8'h00
`define MAP_INTERNAL_EXTENDED_RAM_LIMIT       24'h0007ff
`define MAP_STACK_INTERNAL_EXTENDED_RAM_BASE  11'h100

`endif

// file: src/core_map_pkg.sv
package core_map_pkg;

    typedef enum logic [3:0] {
        OP_IDLE        = 4'h0,
        OP_RD_DIRECT   = 4'h1,
        OP_WR_DIRECT   = 4'h2,
        OP_RD_INDIRECT = 4'h3,
        OP_WR_INDIRECT = 4'h4,
        OP_RD_WORKREG  = 4'h5,
        OP_WR_WORKREG  = 4'h6,
        OP_RD_BIT      = 4'h7,
        OP_WR_BIT      = 4'h8,
        OP_PUSH        = 4'h9,
        OP_POP         = 4'ha,
        OP_XRD         = 4'hb,
        OP_XWR         = 4'hc,
        OP_DP_INC      = 4'hd
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } req_t;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_IDLE  = 3'b010,
        ST_EXT   = 3'b100
    } state_t;

    typedef struct packed {
        state_t      state;
        logic        code_internal;
        logic [10:0] sp;
        logic [7:0]  program_status_word;
        logic [7:0]  pointer_low_byte;
        logic [7:0]  pointer_high_byte;
        logic [7:0]  pointer_page_byte;
        logic        exsp;
        logic        internal_extended_ram_en;
        logic        busy;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic        rsp_unmapped;
        logic        fetch_valid;
        logic        fetch_nop;
        logic        fetch_external;
        logic [23:0] ext_addr;
        logic [7:0]  ext_data;
        logic        ext_oe_n;
        logic        ext_rd_n;
        logic        ext_wr_n;
        logic        ext_cycle;
    } regs_t;

endpackage

// file: src/internal_extended_ram_store.sv
`timescale 1ns/1ns
`default_nettype none

module internal_extended_ram_store #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    input  wire logic          sys_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o
);

    logic [7:0] mem [DEPTH];

    // Write on the edge, read through
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[addr_i];

endmodule

`default_nettype wire

// file: test/core_memory_map_chk.sv
`timescale 1ns/1ns
`default_nettype none

module core_memory_map_chk
    import core_map_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    input wire req_t        req_i,
    input wire logic [7:0]  acc_i,
    input wire logic        code_internal_o,
    input wire logic        fetch_valid_o,
    input wire logic        fetch_nop_o,
    input wire logic        fetch_external_o,
    input wire logic        busy_o,
    input wire logic        rsp_valid_o,
    input wire logic [7:0]  rsp_data_o,
    input wire logic        rsp_unmapped_o,
    input wire logic [1:0]  bank_select_o,
    input wire logic        ext_data_oe_n_o,
    input wire logic        ext_rd_n_o,
    input wire logic        ext_wr_n_o,
    input wire logic        ext_cycle_o
);
    logic [1:0] wr_bank;
    logic       acc_par;

    // Request-side values one cycle back
    always_ff @(posedge sys_clk_i) begin
        wr_bank <= req_i.wdata[4:3];
        acc_par <= ^acc_i;
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    nop_region_a: assert property (fetch_req_i && code_internal_o && !busy_o
        |=> fetch_valid_o
        && fetch_nop_o == ($past(fetch_addr_i) >= 16'hf800)) else $error("nop region wrong");
    fetch_source_a: assert property (fetch_valid_o |->
        fetch_external_o == !code_internal_o) else $error("fetch source wrong");
    answer_time_a: assert property (req_i.op != OP_IDLE && req_i.op != OP_XRD
        && req_i.op != OP_XWR && !busy_o |=> rsp_valid_o) else $error("no answer");
    read_strobe_a: assert property ($fell(ext_rd_n_o) |-> ext_cycle_o && busy_o
        && ext_wr_n_o ##1 ext_rd_n_o && !ext_cycle_o && rsp_valid_o) else $error("read strobe");
    write_strobe_a: assert property (!ext_wr_n_o |-> !ext_data_oe_n_o && ext_cycle_o
        ##1 ext_wr_n_o && ext_data_oe_n_o && rsp_valid_o) else $error("write strobe");
    onchip_move_a: assert property ((req_i.op == OP_XRD || req_i.op == OP_XWR)
        && !busy_o |=> ext_cycle_o != rsp_valid_o) else $error("move timing");
    idle_pins_a: assert property (!ext_cycle_o |-> ext_rd_n_o && ext_wr_n_o
        && ext_data_oe_n_o) else $error("pins active outside cycle");
    bank_follow_a: assert property (req_i.op == OP_WR_DIRECT && req_i.addr == 8'hd0
        && !busy_o |=> bank_select_o == wr_bank) else $error("bank select wrong");
    parity_read_a: assert property (req_i.op == OP_RD_DIRECT && req_i.addr == 8'hd0
        && !busy_o |=> rsp_data_o[0] == acc_par) else $error("parity wrong");
    unmapped_flag_a: assert property (rsp_unmapped_o |-> rsp_valid_o)
        else $error("unmapped without answer");
endmodule

bind core_memory_map core_memory_map_chk chk (.sys_clk_i, .nrst_i, .fetch_req_i, .fetch_addr_i,
    .req_i, .acc_i, .code_internal_o, .fetch_valid_o, .fetch_nop_o, .fetch_external_o, .busy_o,
    .rsp_valid_o, .rsp_data_o, .rsp_unmapped_o, .bank_select_o, .ext_data_oe_n_o, .ext_rd_n_o,
    .ext_wr_n_o, .ext_cycle_o);

`default_nettype wire

// file: test/ext_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

module ext_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        oe_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    output logic      [7:0]  rdata_o = 8'h00,
    output logic      [7:0]  n_cyc_o = 8'h00
);
    logic [7:0] mem [logic [23:0]];
    logic [7:0] last = 8'h00;

    // Store on write strobe, answer on read strobe, else scrambled bus
    always @(posedge sys_clk_i) begin
        #1;
        if (!wr_n_i && !oe_n_i) begin
            mem[addr_i] = wdata_i;
            n_cyc_o = n_cyc_o + 8'h01;
        end
        if (!rd_n_i) begin
            last = mem.exists(addr_i) ? mem[addr_i] : 8'hee;
            rdata_o = last;
            n_cyc_o = n_cyc_o + 8'h01;
        end else begin
            rdata_o = ~last;
        end
    end
endmodule

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench
    import core_map_pkg::*;
;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        strap = 1'b1;
    logic        fetch_req_i = 1'b0;
    logic [15:0] fetch_addr_i = 16'h0000;
    req_t        req_i = '0;
    logic [7:0]  acc_i = 8'h00;
    logic [7:0]  ext_data_i, rsp_data_o, ext_data_o, n_cyc, rd;
    logic [23:0] ext_addr_o;
    logic [1:0]  bank_select_o;
    logic        code_internal_o, fetch_valid_o, fetch_nop_o, fetch_external_o, busy_o;
    logic        rsp_valid_o, rsp_unmapped_o, ext_data_oe_n_o, ext_rd_n_o, ext_wr_n_o;
    logic        ext_cycle_o, um;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    core_memory_map dut (.sys_clk_i, .nrst_i, .code_source_select_i(strap), .fetch_req_i,
        .fetch_addr_i, .req_i, .acc_i, .ext_data_i, .code_internal_o, .fetch_valid_o,
        .fetch_nop_o, .fetch_external_o, .busy_o, .rsp_valid_o, .rsp_data_o, .rsp_unmapped_o,
        .bank_select_o, .ext_addr_o, .ext_data_o, .ext_data_oe_n_o, .ext_rd_n_o, .ext_wr_n_o,
        .ext_cycle_o);

    ext_mem_model mem (.sys_clk_i, .addr_i(ext_addr_o), .wdata_i(ext_data_o),
        .oe_n_i(ext_data_oe_n_o), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o),
        .rdata_o(ext_data_i), .n_cyc_o(n_cyc));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset(input logic s);
        nrst_i = 1'b0;
        strap = s;
        repeat (8) @(posedge sys_clk_i);
        #1 nrst_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic op(input op_t o, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_i = '{o, a, d};
        @(posedge sys_clk_i);
        #1 req_i.op = OP_IDLE;
        while (rsp_valid_o !== 1'b1 && n < 4) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        check(n < 4, 24'h1);
        rd = rsp_data_o;
        um = rsp_unmapped_o;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic rdc(input op_t o, input logic [7:0] a, input logic [7:0] exp);
        op(o, a, 8'h00);
        check(rd, exp);
    endtask

    task automatic dp(input logic [23:0] a);
        op(OP_WR_DIRECT, 8'h84, a[23:16]);
        op(OP_WR_DIRECT, 8'h83, a[15:8]);
        op(OP_WR_DIRECT, 8'h82, a[7:0]);
    endtask

    task automatic fetch(input logic [15:0] a, input logic nop, input logic ext);
        fetch_req_i = 1'b1;
        fetch_addr_i = a;
        @(posedge sys_clk_i);
        #1 fetch_req_i = 1'b0;
        check({fetch_valid_o, fetch_nop_o, fetch_external_o}, {1'b1, nop, ext});
        @(posedge sys_clk_i);
        #1;
    endtask

    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        do_reset(1'b1);
        check(code_internal_o, 24'h1);
        rdc(OP_RD_DIRECT, 8'h81, 8'h07);
        rdc(OP_RD_DIRECT, 8'hb7, 8'h00);
        rdc(OP_RD_DIRECT, 8'hd0, 8'h00);
        rdc(OP_RD_DIRECT, 8'haf, 8'h00);
        fetch(16'hf7ff, 1'b0, 1'b0);
        fetch(16'hf800, 1'b1, 1'b0);
        fetch(16'hffff, 1'b1, 1'b0);
        op(OP_PUSH, 8'h00, 8'h55);
        rdc(OP_RD_DIRECT, 8'h08, 8'h55);
        rdc(OP_RD_DIRECT, 8'h81, 8'h08);
        rdc(OP_POP, 8'h00, 8'h55);
        for (int b = 0; b < 4; b++) begin
            op(OP_WR_DIRECT, 8'hd0, 8'(b << 3));
            check(bank_select_o, 24'(b));
            op(OP_WR_WORKREG, 8'h02, 8'ha0 + 8'(b));
        end
        for (int b = 0; b < 4; b++)
            rdc(OP_RD_INDIRECT, 8'(b * 8 + 2), 8'ha0 + 8'(b));
        rdc(OP_RD_WORKREG, 8'h02, 8'ha3);
        op(OP_WR_DIRECT, 8'h20, 8'h00);
        op(OP_WR_DIRECT, 8'h2f, 8'h00);
        op(OP_WR_BIT, 8'h00, 8'h01);
        op(OP_WR_BIT, 8'h7f, 8'h01);
        rdc(OP_RD_DIRECT, 8'h20, 8'h01);
        rdc(OP_RD_DIRECT, 8'h2f, 8'h80);
        rdc(OP_RD_BIT, 8'h7f, 8'h01);
        op(OP_WR_BIT, 8'hd3, 8'h00);
        check(bank_select_o, 24'h2);
        rdc(OP_RD_BIT, 8'hd4, 8'h01);
        acc_i = 8'h07;
        rdc(OP_RD_DIRECT, 8'hd0, 8'h11);
        op(OP_WR_INDIRECT, 8'h90, 8'h3c);
        rdc(OP_RD_DIRECT, 8'h90, 8'h00);
        check(um, 24'h1);
        rdc(OP_RD_INDIRECT, 8'h90, 8'h3c);
        dp(24'h12ffff);
        op(OP_DP_INC, 8'h00, 8'h00);
        rdc(OP_RD_DIRECT, 8'h82, 8'h00);
        rdc(OP_RD_DIRECT, 8'h83, 8'h00);
        rdc(OP_RD_DIRECT, 8'h84, 8'h13);
        op(OP_XWR, 8'h00, 8'h5a);
        check(ext_addr_o, 24'h130000);
        rdc(OP_XRD, 8'h00, 8'h5a);
        dp(24'h0007ff);
        op(OP_XWR, 8'h00, 8'h11);
        op(OP_WR_DIRECT, 8'haf, 8'h01);
        op(OP_XWR, 8'h00, 8'ha5);
        rdc(OP_XRD, 8'h00, 8'ha5);
        check(n_cyc, 24'h3);
        dp(24'h000800);
        op(OP_XWR, 8'h00, 8'h22);
        check(n_cyc, 24'h4);
        op(OP_WR_DIRECT, 8'haf, 8'h00);
        dp(24'h0007ff);
        rdc(OP_XRD, 8'h00, 8'h11);
        op(OP_WR_DIRECT, 8'h81, 8'hff);
        op(OP_PUSH, 8'h00, 8'h66);
        rdc(OP_RD_DIRECT, 8'h81, 8'h00);
        rdc(OP_RD_DIRECT, 8'h00, 8'h66);
        op(OP_WR_DIRECT, 8'haf, 8'hff);
        rdc(OP_RD_DIRECT, 8'haf, 8'h81);
        op(OP_WR_DIRECT, 8'h81, 8'hff);
        op(OP_PUSH, 8'h00, 8'h77);
        rdc(OP_RD_DIRECT, 8'hb7, 8'h01);
        rdc(OP_RD_DIRECT, 8'h81, 8'h00);
        dp(24'h000100);
        rdc(OP_XRD, 8'h00, 8'h77);
        rdc(OP_POP, 8'h00, 8'h77);
        rdc(OP_RD_DIRECT, 8'hb7, 8'h00);
        do_reset(1'b0);
        check(code_internal_o, 24'h0);
        check(bank_select_o, 24'h0);
        fetch(16'hf800, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule

`default_nettype wire
